// ### rbt_pkg.sv
/*
 * Shared constants and types of the registered bidirectional bus transceiver.
 * Assumes a single APB clock domain; no other file redefines these values.
 */
`default_nettype none

package rbt_pkg;

    // ----------------------------------------------------------------
    // widths and depths
    // ----------------------------------------------------------------
    localparam int unsigned CHAN_W    = 8;
    localparam int unsigned LOG_DEPTH = 4;
    localparam int unsigned APB_AW    = 12;
    localparam int unsigned APB_DW    = 32;

    // ----------------------------------------------------------------
    // register byte addresses
    // ----------------------------------------------------------------
    localparam logic [APB_AW-1:0] OFS_CTRL   = 12'h000;
    localparam logic [APB_AW-1:0] OFS_STORED = 12'h004;
    localparam logic [APB_AW-1:0] OFS_LOG    = 12'h008;
    localparam logic [APB_AW-1:0] OFS_STATUS = 12'h00C;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int unsigned STORED_A_LSB  = 0;
    localparam int unsigned STORED_B_LSB  = 8;
    localparam int unsigned LOG_VALID_BIT = 8;
    localparam int unsigned STAT_EMPTY    = 0;
    localparam int unsigned STAT_FULL     = 1;
    localparam int unsigned STAT_OVFL     = 2;

    // ----------------------------------------------------------------
    // control register layout, bit 3 downward
    // ----------------------------------------------------------------
    typedef struct packed {
        logic b_to_a_source_select;
        logic a_to_b_source_select;
        logic dir;
        logic oe_n;
    } rbt_ctrl_s;

    localparam int unsigned CTRL_W   = 4;
    localparam logic [3:0]  CTRL_RST = 4'h1;

endpackage

`default_nettype wire

// ### rbt_transceiver.sv
/*
 * Registered bidirectional bus transceiver with APB control, plus the
 * small capture log FIFO it feeds.
 * Assumes pins and capture clocks are asynchronous to pclk and are slower
 * than pclk / 3; pin wires are resolved outside from the enables.
 */
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// capture log fifo, depth a power of two
// ----------------------------------------------------------------
module rbt_fifo #(
    parameter int unsigned W = 8,
    parameter int unsigned D = 4
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // fill side
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    // drain side
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    localparam int unsigned AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW:0]         wr;
        logic [AW:0]         rd;
    } rbt_fifo_s;

    rbt_fifo_s q;
    rbt_fifo_s d;
    logic      full;
    logic      empty;

    assign full      = (q.wr[AW] != q.rd[AW]) && (q.wr[AW-1:0] == q.rd[AW-1:0]);
    assign empty     = (q.wr == q.rd);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = q.mem[q.rd[AW-1:0]];

    always_comb begin
        d = q;
        if (in_valid && in_ready) begin
            d.mem[q.wr[AW-1:0]] = in_data;
            d.wr                = q.wr + 1'b1;
        end
        if (out_valid && out_ready) begin
            d.rd = q.rd + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

// How it works
// - capture clock edges load A and B registers
// - capture ignores enable and direction
// - undriven port still captured while other driven
// - enable high: no port driven, registers still load on capture edges
// - enable low: direction picks the driven port
// - direction low, select low: live B to A
// - direction low, select high: stored B to A
// - direction high, select low: live A to B
// - direction high, select high: stored A to B
// - never drive both ports at once
module rbt_transceiver #(
    parameter int unsigned CHAN_W    = rbt_pkg::CHAN_W,
    parameter int unsigned LOG_DEPTH = rbt_pkg::LOG_DEPTH
) (
    // clock and reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // apb slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [rbt_pkg::APB_AW-1:0]  paddr,
    input  wire logic [rbt_pkg::APB_DW-1:0]  pwdata,
    output logic [rbt_pkg::APB_DW-1:0]       prdata,
    output logic                             pready,
    output logic                             pslverr,
    // capture clocks from pins
    input  wire logic                        a_to_b_capture_clock,
    input  wire logic                        b_to_a_capture_clock,
    // port a pins
    input  wire logic [CHAN_W-1:0]           port_a_data_in,
    output logic [CHAN_W-1:0]                port_a_data_out,
    output logic                             port_a_data_oe,
    // port b pins
    input  wire logic [CHAN_W-1:0]           port_b_data_in,
    output logic [CHAN_W-1:0]                port_b_data_out,
    output logic                             port_b_data_oe,
    // capture log back-pressure
    output logic                             capture_log_ready
);
    import rbt_pkg::*;

    typedef struct packed {
        logic [1:0]             ab_clk_sync;
        logic                   ab_clk_prev;
        logic [1:0]             ba_clk_sync;
        logic                   ba_clk_prev;
        logic [1:0][CHAN_W-1:0] a_sync;
        logic [1:0][CHAN_W-1:0] b_sync;
        logic [CHAN_W-1:0]      a_store;
        logic [CHAN_W-1:0]      b_store;
        rbt_ctrl_s              ctrl;
        logic [CHAN_W-1:0]      a_out;
        logic                   a_oe;
        logic [CHAN_W-1:0]      b_out;
        logic                   b_oe;
        logic [APB_DW-1:0]      prdata;
        logic                   pready;
        logic                   pslverr;
        logic                   overflow;
        logic                   log_ready;
    } rbt_state_s;

    rbt_state_s        q;
    rbt_state_s        d;

    logic              ab_edge;
    logic              ba_edge;
    logic [CHAN_W-1:0] a_in;
    logic [CHAN_W-1:0] b_in;
    logic              log_in_ready;
    logic              log_valid;
    logic [CHAN_W-1:0] log_data;
    logic              log_pop;
    logic              setup;
    logic              access;

    // ----------------------------------------------------------------
    // synchronised pins and capture edges
    // ----------------------------------------------------------------
    assign a_in    = q.a_sync[1];
    assign b_in    = q.b_sync[1];
    assign ab_edge = q.ab_clk_sync[1] && !q.ab_clk_prev;
    assign ba_edge = q.ba_clk_sync[1] && !q.ba_clk_prev;
    assign setup   = psel && !penable;
    assign access  = psel && penable && q.pready;
    assign log_pop = access && !pwrite && (paddr == OFS_LOG);

    rbt_fifo #(
        .W (CHAN_W),
        .D (LOG_DEPTH)
    ) u_log (
        .clk       (pclk),
        .rst_n     (presetn),
        .in_valid  (ab_edge),
        .in_data   (a_in),
        .in_ready  (log_in_ready),
        .out_valid (log_valid),
        .out_data  (log_data),
        .out_ready (log_pop)
    );

    always_comb begin
        d = q;
        d.ab_clk_sync = {q.ab_clk_sync[0], a_to_b_capture_clock};
        d.ba_clk_sync = {q.ba_clk_sync[0], b_to_a_capture_clock};
        d.ab_clk_prev = q.ab_clk_sync[1];
        d.ba_clk_prev = q.ba_clk_sync[1];
        d.a_sync      = {q.a_sync[0], port_a_data_in};
        d.b_sync      = {q.b_sync[0], port_b_data_in};

        // capture, never gated by the output controls
        if (ab_edge) begin
            d.a_store = a_in;
        end
        if (ba_edge) begin
            d.b_store = b_in;
        end

        // output steering from the controls
        d.a_oe  = !q.ctrl.oe_n && !q.ctrl.dir;
        d.b_oe  = !q.ctrl.oe_n && q.ctrl.dir;
        d.a_out = q.ctrl.b_to_a_source_select ? q.b_store : b_in;
        d.b_out = q.ctrl.a_to_b_source_select ? q.a_store : a_in;

        // overflow sticky, set wins over clear
        if (access && pwrite && (paddr == OFS_STATUS) && pwdata[STAT_OVFL]) begin
            d.overflow = 1'b0;
        end
        if (ab_edge && !log_in_ready) begin
            d.overflow = 1'b1;
        end
        d.log_ready = log_in_ready;

        // apb: answer one cycle after setup
        d.pready  = setup;
        d.pslverr = 1'b0;
        d.prdata  = '0;
        if (setup) begin
            if (paddr == OFS_CTRL) begin
                d.prdata[CTRL_W-1:0] = q.ctrl;
            end else if (paddr == OFS_STORED) begin
                d.prdata[STORED_A_LSB +: CHAN_W] = q.a_store;
                d.prdata[STORED_B_LSB +: CHAN_W] = q.b_store;
            end else if (paddr == OFS_LOG) begin
                d.prdata[CHAN_W-1:0]    = log_data;
                d.prdata[LOG_VALID_BIT] = log_valid;
            end else if (paddr == OFS_STATUS) begin
                d.prdata[STAT_EMPTY] = !log_valid;
                d.prdata[STAT_FULL]  = !log_in_ready;
                d.prdata[STAT_OVFL]  = q.overflow;
            end else begin
                d.pslverr = 1'b1;
            end
        end
        if (access && pwrite && (paddr == OFS_CTRL)) begin
            d.ctrl = pwdata[CTRL_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q      <= '0;
            q.ctrl <= CTRL_RST;
        end else begin
            q <= d;
        end
    end

    assign prdata            = q.prdata;
    assign pready            = q.pready;
    assign pslverr           = q.pslverr;
    assign port_a_data_out   = q.a_out;
    assign port_a_data_oe    = q.a_oe;
    assign port_b_data_out   = q.b_out;
    assign port_b_data_oe    = q.b_oe;
    assign capture_log_ready = q.log_ready;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_cap_a;
        @(posedge pclk) disable iff (!presetn)
        ab_edge |=> (q.a_store == $past(a_in));
    endproperty
    a_cap_a: assert property (p_cap_a) else $error("a register missed capture");

    property p_cap_b_driving;
        @(posedge pclk) disable iff (!presetn)
        (ba_edge && !q.ctrl.oe_n) |=> (q.b_store == $past(b_in));
    endproperty
    a_cap_b_driving: assert property (p_cap_b_driving) else $error("b capture gated");

    property p_cap_undriven;
        @(posedge pclk) disable iff (!presetn)
        (ab_edge && ba_edge && port_b_data_oe) |=>
            (q.a_store == $past(a_in)) && (q.b_store == $past(b_in));
    endproperty
    a_cap_undriven: assert property (p_cap_undriven) else $error("undriven capture lost");

    property p_isolate;
        @(posedge pclk) disable iff (!presetn)
        q.ctrl.oe_n |=> (!port_a_data_oe && !port_b_data_oe);
    endproperty
    a_isolate: assert property (p_isolate) else $error("port driven in isolation");

    property p_hold;
        @(posedge pclk) disable iff (!presetn)
        (!ab_edge && !ba_edge) |=> $stable(q.a_store) && $stable(q.b_store);
    endproperty
    a_hold: assert property (p_hold) else $error("register changed without edge");

    property p_dir;
        @(posedge pclk) disable iff (!presetn)
        !q.ctrl.oe_n |=> (port_a_data_oe == !$past(q.ctrl.dir))
            && (port_b_data_oe == $past(q.ctrl.dir));
    endproperty
    a_dir: assert property (p_dir) else $error("wrong port driven");

    property p_live_b_to_a;
        @(posedge pclk) disable iff (!presetn)
        (!q.ctrl.oe_n && !q.ctrl.dir && !q.ctrl.b_to_a_source_select) |=>
            port_a_data_oe && (port_a_data_out == $past(b_in));
    endproperty
    a_live_b_to_a: assert property (p_live_b_to_a) else $error("live b not on a");

    property p_stored_b_to_a;
        @(posedge pclk) disable iff (!presetn)
        (!q.ctrl.oe_n && !q.ctrl.dir && q.ctrl.b_to_a_source_select) |=>
            port_a_data_oe && (port_a_data_out == $past(q.b_store));
    endproperty
    a_stored_b_to_a: assert property (p_stored_b_to_a) else $error("stored b not on a");

    property p_live_a_to_b;
        @(posedge pclk) disable iff (!presetn)
        (!q.ctrl.oe_n && q.ctrl.dir && !q.ctrl.a_to_b_source_select) |=>
            port_b_data_oe && (port_b_data_out == $past(a_in));
    endproperty
    a_live_a_to_b: assert property (p_live_a_to_b) else $error("live a not on b");

    property p_stored_a_to_b;
        @(posedge pclk) disable iff (!presetn)
        (!q.ctrl.oe_n && q.ctrl.dir && q.ctrl.a_to_b_source_select) |=>
            port_b_data_oe && (port_b_data_out == $past(q.a_store));
    endproperty
    a_stored_a_to_b: assert property (p_stored_a_to_b) else $error("stored a not on b");

    property p_one_driver;
        @(posedge pclk) disable iff (!presetn)
        !(port_a_data_oe && port_b_data_oe);
    endproperty
    a_one_driver: assert property (p_one_driver) else $error("both ports driven");

    property p_follow;
        @(posedge pclk) disable iff (!presetn)
        (ab_edge && !q.ctrl.oe_n && q.ctrl.dir && q.ctrl.a_to_b_source_select)
            ##1 (!q.ctrl.oe_n && q.ctrl.dir && q.ctrl.a_to_b_source_select)
            |=> (port_b_data_out == $past(a_in, 2));
    endproperty
    a_follow: assert property (p_follow) else $error("b port stale after capture");

    property p_apb_answer;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready ##1 !pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("apb answer not one cycle");

endmodule

`default_nettype wire

// ### rbt_bus_model.sv
/*
 * Model of the system logic that drives the two parallel buses.
 * Assumes the device's drive values and enables come straight from its pins;
 * the bench says what this side wants to put on each bus.
 */
`timescale 1ns/1ns
`default_nettype none

module rbt_bus_model (
    // values this side wants on each bus
    input  wire logic [7:0] a_drive,
    input  wire logic [7:0] b_drive,
    // device drive side
    input  wire logic [7:0] dev_a_out,
    input  wire logic       dev_a_oe,
    input  wire logic [7:0] dev_b_out,
    input  wire logic       dev_b_oe,
    // resolved wire levels
    output logic      [7:0] a_level,
    output logic      [7:0] b_level
);
    // backs off whichever bus the device is driving
    assign a_level = dev_a_oe ? dev_a_out : a_drive;
    assign b_level = dev_b_oe ? dev_b_out : b_drive;
endmodule

`default_nettype wire

// ### rbt_testbench.sv
/*
 * Self-checking bench of the transceiver: apb tasks, capture pulses, modes.
 * Assumes the bus model resolves both buses and pclk runs at 250 MHz.
 */
`timescale 1ns/1ns
`default_nettype none

`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end

module testbench;
    import rbt_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [APB_AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, er, clk_ab = 0, clk_ba = 0, oe_a, oe_b, log_rdy;
    logic [7:0] a_drv = 8'h00, b_drv = 8'h00, a_lvl, b_lvl, a_out, b_out;
    int fail_count = 0, compares = 0;

    always #2 pclk = ~pclk;

    rbt_transceiver #(.CHAN_W(8), .LOG_DEPTH(4)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .a_to_b_capture_clock(clk_ab),
        .b_to_a_capture_clock(clk_ba), .port_a_data_in(a_lvl),
        .port_a_data_out(a_out), .port_a_data_oe(oe_a), .port_b_data_in(b_lvl),
        .port_b_data_out(b_out), .port_b_data_oe(oe_b), .capture_log_ready(log_rdy));

    rbt_bus_model bus (
        .a_drive(a_drv), .b_drive(b_drv), .dev_a_out(a_out), .dev_a_oe(oe_a),
        .dev_b_out(b_out), .dev_b_oe(oe_b), .a_level(a_lvl), .b_level(b_lvl));

    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [APB_AW-1:0] ad,
                       input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            fail_count++;
            final_report();
        end
        rd = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
    endtask

    // drive both buses, then raise the chosen capture clocks
    task automatic pulse(input logic [7:0] a, input logic [7:0] b,
                         input logic ca, input logic cb);
        a_drv <= a; b_drv <= b;
        repeat (4) @(posedge pclk);
        clk_ab <= ca; clk_ba <= cb;
        repeat (4) @(posedge pclk);
        clk_ab <= 0; clk_ba <= 0;
        repeat (4) @(posedge pclk);
    endtask

    task automatic t_reset;
        repeat (2) @(posedge pclk);
        `CHK({oe_a, oe_b, log_rdy}, 3'b001)
        apb(0, OFS_CTRL, 0);
        `CHK(rd, 32'h0000_0001)
    endtask

    task automatic t_isolation;
        pulse(8'h5A, 8'hA5, 1, 1);
        apb(0, OFS_STORED, 0);
        `CHK(rd[15:0], 16'hA55A)
        pulse(8'hFF, 8'h00, 0, 0);
        apb(0, OFS_STORED, 0);
        `CHK(rd[15:0], 16'hA55A)
        `CHK({oe_a, oe_b}, 2'b00)
    endtask

    task automatic t_modes;
        logic [3:0] c;
        a_drv <= 8'h3C; b_drv <= 8'hC3;
        for (int m = 0; m < 4; m++) begin
            c = m[0] ? {1'b0, m[1], 2'b10} : {m[1], 3'b000};
            apb(1, OFS_CTRL, {28'h000_0000, c});
            repeat (6) @(posedge pclk);
            `CHK({oe_a, oe_b}, m[0] ? 2'b01 : 2'b10)
            if (!m[0]) `CHK(a_out, m[1] ? 8'hA5 : 8'hC3)
            else `CHK(b_out, m[1] ? 8'h5A : 8'h3C)
        end
    endtask

    // port a undriven, port b carries live a: both registers take the a data
    task automatic t_capture_both_while_driving;
        apb(1, OFS_CTRL, 32'h0000_0002);
        pulse(8'h69, 8'h00, 1, 1);
        `CHK({oe_a, oe_b}, 2'b01)
        `CHK(b_out, 8'h69)
        apb(0, OFS_STORED, 0);
        `CHK(rd[15:0], 16'h6969)
    endtask

    task automatic t_capture_while_driving;
        apb(1, OFS_CTRL, 32'h0000_0006);
        pulse(8'h96, 8'h00, 1, 0);
        `CHK(b_out, 8'h96)
        `CHK(oe_b, 1'b1)
        apb(0, OFS_STORED, 0);
        `CHK(rd[7:0], 8'h96)
    endtask

    task automatic t_log;
        apb(1, OFS_CTRL, 32'h0000_0001);
        for (int i = 0; i < 8; i++) begin
            apb(0, OFS_LOG, 0);
            if (rd[8] !== 1'b1) break;
        end
        apb(1, OFS_STATUS, 32'h0000_0004);
        for (int i = 1; i < 6; i++) pulse(8'(i * 17), 8'h00, 1, 0);
        apb(0, OFS_STATUS, 0);
        `CHK({rd[2:0], log_rdy}, 4'b1100)
        for (int i = 1; i < 5; i++) begin
            apb(0, OFS_LOG, 0);
            `CHK(rd[8:0], {1'b1, 8'(i * 17)})
        end
        apb(0, OFS_LOG, 0);
        `CHK(rd[8], 1'b0)
        apb(0, OFS_STATUS, 0);
        `CHK(rd[2:0], 3'b101)
        apb(1, OFS_STATUS, 32'h0000_0004);
        apb(0, OFS_STATUS, 0);
        `CHK(rd[2:0], 3'b001)
        apb(1, 12'h010, 32'hFFFF_FFFF);
        `CHK(er, 1'b1)
        apb(0, 12'h010, 0);
        `CHK({er, rd}, {1'b1, 32'h0000_0000})
        apb(1, OFS_STORED, 32'h0000_0000);
        apb(0, OFS_STORED, 0);
        `CHK(rd[7:0], 8'h55)
    endtask

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1;
        t_reset();
        t_isolation();
        t_modes();
        t_capture_both_while_driving();
        t_capture_while_driving();
        t_log();
        final_report();
    end
endmodule

`default_nettype wire
